// ### logic/pcsia_pkg.sv
package pcsia_pkg;
  // Program counter and stack geometry
  localparam int PC_W          = 15;
  localparam int PCH_W         = 7;
  localparam int SP_W          = 5;
  localparam int STACK_DEPTH   = 16;
  localparam logic [4:0] SP_EMPTY    = 5'h1F;
  localparam logic [4:0] SP_LAST     = 5'h0F;
  localparam logic [4:0] SP_RESET    = 5'h1F;
  localparam logic [14:0] PC_RESET   = 15'h0000;
  localparam logic [6:0] LATCH_RESET = 7'h00;
  localparam int CALL_LOW_BITS = 11;

  // Register port offsets (core register addresses within every bank)
  localparam logic [3:0] OFF_PCL     = 4'h2;
  localparam logic [3:0] OFF_PC_HIGH_LATCH  = 4'hA;
  localparam logic [3:0] OFF_SP      = 4'h0;
  localparam logic [3:0] OFF_TOP_OF_STACK_LOW    = 4'h1;
  localparam logic [3:0] OFF_TOP_OF_STACK_HIGH    = 4'h3;
  localparam logic [3:0] OFF_FSR0L   = 4'h4;
  localparam logic [3:0] OFF_FSR0H   = 4'h5;
  localparam logic [3:0] OFF_FSR1L   = 4'h6;
  localparam logic [3:0] OFF_FSR1H   = 4'h7;
  localparam logic [3:0] OFF_FLAGS   = 4'h8;

  // Indirect map
  localparam logic [15:0] IND_PORT0  = 16'h0000;
  localparam logic [15:0] IND_PORT1  = 16'h0001;
  localparam logic [15:0] TRAD_TOP   = 16'h0FFF;
  localparam logic [15:0] LIN_BASE   = 16'h2000;
  localparam logic [15:0] LIN_TOP    = 16'h29AF;
  localparam logic [7:0]  GPR_SPAN   = 8'h50;
  localparam logic [6:0]  GPR_START  = 7'h20;
  localparam logic [6:0]  BANK_SIZE  = 7'h00;
  localparam int FLASH_BIT           = 15;
  localparam int FLASH_EXTRA_CYCLES  = 1;

  // Program counter operations
  typedef enum logic [3:0] {
    PCSIA_OP_NONE, PCSIA_OP_INC, PCSIA_OP_WRITE_PCL, PCSIA_OP_CALL, PCSIA_OP_CALL_VIA_WORKING,
    PCSIA_OP_BRW, PCSIA_OP_BRA, PCSIA_OP_RETURN, PCSIA_OP_RETURN_WITH_LITERAL, PCSIA_OP_RETURN_FROM_INTERRUPT,
    PCSIA_OP_VECTOR
  } pcsia_op_e;

  typedef struct packed {
    pcsia_op_e   op;
    logic [10:0] operand;
    logic [7:0]  wreg;
    logic [14:0] vector;
  } pcsia_cmd_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pcsia_reg_req_s;

  typedef struct packed {
    logic        valid;
    logic        is_write;
    logic        sel;
    logic [7:0]  wdata;
  } pcsia_ind_req_s;

  typedef struct packed {
    logic        data_en;
    logic        data_wr;
    logic [11:0] data_addr;
    logic [7:0]  data_wdata;
    logic        flash_en;
    logic [14:0] flash_addr;
  } pcsia_mem_req_s;
endpackage

// ### logic/pcsia_core.sv
`timescale 1ns/100ps
// Behaviour
// - PC is 15 bits, low byte accessible
// - Any reset clears the whole PC
// - Writing low byte loads upper bits from latch
// - Call loads 11 low operand bits and four high latch bits
// - Computed call pushes, uses working and latch
// - Working branch: next address plus unsigned working
// - Immediate branch: next address plus signed operand
// - Sixteen-entry 15-bit stack outside address spaces
// - Calls and vectoring push, returns pop, latch kept
// - Stack wraps circularly when error reset off
// - Overflow and underflow flags always set
// - Five-bit pointer selects entry for top access
// - Push increments then writes, pop reads then decrements
// - Empty pointer is 0x1F, first push uses 0
// - Stack error resets device when enabled
// - Indirect port uses 16-bit pointer address
// - Pointer at indirect port reads zero, no write
// - Low 4K pointer range maps banked data directly
// - Linear region views the 80-byte RAM of banks 0 to 30
// - Unimplemented linear reads return zero
// - Pointer top bit reaches flash low byte, read-only
// - Flash indirect access takes one extra cycle
// - Non-power resets leave pointer at empty state
module pcsia_core
  import pcsia_pkg::*;
#(
  parameter int LIN_BANKS = 32
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     por_rst,
  // Configuration
  input  wire logic                     stack_error_reset_enable,
  // Instruction sequencing
  input  wire pcsia_pkg::pcsia_cmd_s    cmd,
  output logic [14:0]                   pc_r,
  output logic                          stack_reset_req_r,
  output logic                          stack_overflow_flag_r,
  output logic                          stack_underflow_flag_r,
  // Register port
  input  wire pcsia_pkg::pcsia_reg_req_s reg_req,
  output logic [7:0]                    reg_rdata_r,
  // Indirect data port
  input  wire pcsia_pkg::pcsia_ind_req_s ind_req,
  input  wire logic [7:0]               mem_rdata,
  input  wire logic [13:0]              flash_rdata,
  output pcsia_pkg::pcsia_mem_req_s     mem_req_r,
  output logic [7:0]                    ind_rdata_r,
  output logic                          ind_stall_r
);
  import pcsia_pkg::*;

  logic [14:0] stack_mem [STACK_DEPTH];
  logic [6:0]  pc_high_latch_r;
  logic [4:0]  stack_pointer_reg_r;
  logic [7:0]  ptr_lo_r [2];
  logic [7:0]  ptr_hi_r [2];
  logic [14:0] pc_next;
  logic [4:0]  sp_push, sp_pop;
  logic        is_push, is_pop, ovf_ev, unf_ev;
  logic [15:0] ind_addr;

  // Entry index for a pointer value; the wrap follows the low four bits
  function automatic logic [3:0] slot(input logic [4:0] sp);
    return sp[3:0];
  endfunction

  // Register write decode
  function automatic logic reg_hit(input pcsia_reg_req_s r, input logic [3:0] off);
    return r.wr && (r.addr == off);
  endfunction

  assign is_push  = (cmd.op == PCSIA_OP_CALL) || (cmd.op == PCSIA_OP_CALL_VIA_WORKING) ||
                    (cmd.op == PCSIA_OP_VECTOR);
  assign is_pop   = (cmd.op == PCSIA_OP_RETURN) || (cmd.op == PCSIA_OP_RETURN_WITH_LITERAL) ||
                    (cmd.op == PCSIA_OP_RETURN_FROM_INTERRUPT);
  assign sp_push  = (stack_pointer_reg_r == SP_EMPTY) ? 5'h00 :
                    5'(stack_pointer_reg_r + 5'h01);
  assign sp_pop   = (stack_pointer_reg_r == 5'h00) ? SP_EMPTY :
                    5'(stack_pointer_reg_r - 5'h01);
  // Overflow: pushing while the last level is in use
  assign ovf_ev   = is_push && (stack_pointer_reg_r == SP_LAST ||
                    (stack_pointer_reg_r[4] && stack_pointer_reg_r != SP_EMPTY));
  assign unf_ev   = is_pop && (stack_pointer_reg_r == SP_EMPTY);

  // Next program counter
  always_comb begin
    pc_next = pc_r;
    case (cmd.op)
      PCSIA_OP_INC:    pc_next = 15'(pc_r + 15'h0001);
      PCSIA_OP_WRITE_PCL: pc_next = {pc_high_latch_r, reg_req.wdata};
      PCSIA_OP_CALL:   pc_next = {pc_high_latch_r[6:3], cmd.operand};
      PCSIA_OP_CALL_VIA_WORKING:  pc_next = {pc_high_latch_r, cmd.wreg};
      PCSIA_OP_BRW:    pc_next = 15'(pc_r + 15'h0001 + {7'h00, cmd.wreg});
      PCSIA_OP_BRA:    pc_next = 15'(pc_r + 15'h0001 +
                                     {{6{cmd.operand[8]}}, cmd.operand[8:0]});
      PCSIA_OP_RETURN, PCSIA_OP_RETURN_WITH_LITERAL, PCSIA_OP_RETURN_FROM_INTERRUPT:
                       pc_next = stack_mem[slot(stack_pointer_reg_r)];
      PCSIA_OP_VECTOR: pc_next = cmd.vector;
      default:         pc_next = pc_r;
    endcase
  end

  // Program counter; writing the low byte directly takes priority over the next-PC path
  always_ff @(posedge core_clk) begin
    if (sys_rst || stack_reset_req_r) begin
      pc_r <= PC_RESET;
    end else if (reg_hit(reg_req, OFF_PCL)) begin
      pc_r <= {pc_high_latch_r, reg_req.wdata};
    end else begin
      pc_r <= pc_next;
    end
  end

  // High latch is only touched by software, never by push or pop
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc_high_latch_r <= LATCH_RESET;
    end else if (reg_hit(reg_req, OFF_PC_HIGH_LATCH)) begin
      pc_high_latch_r <= reg_req.wdata[6:0];
    end
  end

  // Stack pointer; power-on leaves it unknown in silicon, empty here too
  always_ff @(posedge core_clk) begin
    if (sys_rst || stack_reset_req_r) begin
      stack_pointer_reg_r <= SP_RESET;
    end else if (is_push) begin
      stack_pointer_reg_r <= sp_push;
    end else if (is_pop) begin
      stack_pointer_reg_r <= sp_pop;
    end else if (reg_hit(reg_req, OFF_SP)) begin
      stack_pointer_reg_r <= reg_req.wdata[4:0];
    end
  end

  // Stack storage, wraps when error reset is off
  generate
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
      always_ff @(posedge core_clk) begin
        if (is_push && slot(sp_push) == 4'(i)) begin
          stack_mem[i] <= (cmd.op == PCSIA_OP_VECTOR) ? pc_r :
                          15'(pc_r + 15'h0001);
        end else if (slot(stack_pointer_reg_r) == 4'(i) && reg_hit(reg_req, OFF_TOP_OF_STACK_LOW)) begin
          stack_mem[i][7:0] <= reg_req.wdata;
        end else if (slot(stack_pointer_reg_r) == 4'(i) && reg_hit(reg_req, OFF_TOP_OF_STACK_HIGH)) begin
          stack_mem[i][14:8] <= reg_req.wdata[6:0];
        end
      end
    end
  endgenerate

  // Error flags and stack error reset
  always_ff @(posedge core_clk) begin
    if (por_rst) begin
      stack_overflow_flag_r  <= 1'b0;
      stack_underflow_flag_r <= 1'b0;
    end else begin
      if (ovf_ev) begin
        stack_overflow_flag_r <= 1'b1;
      end else if (reg_hit(reg_req, OFF_FLAGS) && !reg_req.wdata[0]) begin
        stack_overflow_flag_r <= 1'b0;
      end
      if (unf_ev) begin
        stack_underflow_flag_r <= 1'b1;
      end else if (reg_hit(reg_req, OFF_FLAGS) && !reg_req.wdata[1]) begin
        stack_underflow_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stack_reset_req_r <= 1'b0;
    end else begin
      stack_reset_req_r <= stack_error_reset_enable && (ovf_ev || unf_ev);
    end
  end

  // File-select pointers
  generate
    for (genvar n = 0; n < 2; n++) begin : g_ptr
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          ptr_lo_r[n] <= 8'h00;
          ptr_hi_r[n] <= 8'h00;
        end else begin
          if (reg_hit(reg_req, n == 0 ? OFF_FSR0L : OFF_FSR1L)) begin
            ptr_lo_r[n] <= reg_req.wdata;
          end
          if (reg_hit(reg_req, n == 0 ? OFF_FSR0H : OFF_FSR1H)) begin
            ptr_hi_r[n] <= reg_req.wdata;
          end
        end
      end
    end
  endgenerate

  assign ind_addr = {ptr_hi_r[ind_req.sel], ptr_lo_r[ind_req.sel]};

  // Linear decode: bank and offset into that bank's RAM window
  logic [15:0] lin_off;
  logic [4:0]  lin_bank;
  logic [6:0]  lin_rem;
  logic        lin_ok;
  always_comb begin
    lin_off  = 16'(ind_addr - LIN_BASE);
    lin_bank = 5'(lin_off / 16'(GPR_SPAN));
    lin_rem  = 7'(lin_off % 16'(GPR_SPAN));
    lin_ok   = (ind_addr >= LIN_BASE) && (ind_addr <= LIN_TOP) &&
               (32'(lin_bank) < LIN_BANKS);
  end

  typedef enum {PCSIA_IDLE, PCSIA_FLASH_WAIT} pcsia_ind_e;
  pcsia_ind_e ind_state_r;
  logic       kind_r; // 1: read result comes from data memory, 0: zero, or flash data after a flash request

  // Indirect access; outputs registered one cycle after the request
  // Read data are taken at the next edge, so memory must answer while mem_req_r stands
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_req_r   <= '0;
      ind_rdata_r <= 8'h00;
      ind_stall_r <= 1'b0;
      ind_state_r <= PCSIA_IDLE;
      kind_r      <= 1'b0;
    end else begin
      mem_req_r   <= '0;
      ind_stall_r <= 1'b0;
      case (ind_state_r)
        PCSIA_IDLE: begin
          if (kind_r) begin
            ind_rdata_r <= mem_rdata;
          end
          kind_r <= 1'b0;
          if (ind_req.valid) begin
            ind_rdata_r <= 8'h00;
            if (ind_addr[FLASH_BIT]) begin
              mem_req_r.flash_en   <= !ind_req.is_write;
              mem_req_r.flash_addr <= ind_addr[14:0];
              ind_stall_r          <= 1'b1;
              ind_state_r          <= PCSIA_FLASH_WAIT;
            end else if (ind_addr == IND_PORT0 || ind_addr == IND_PORT1) begin
              mem_req_r <= '0;
            end else if (ind_addr <= TRAD_TOP) begin
              mem_req_r.data_en    <= 1'b1;
              mem_req_r.data_wr    <= ind_req.is_write;
              mem_req_r.data_addr  <= ind_addr[11:0];
              mem_req_r.data_wdata <= ind_req.wdata;
              kind_r               <= !ind_req.is_write;
            end else if (lin_ok) begin
              mem_req_r.data_en    <= 1'b1;
              mem_req_r.data_wr    <= ind_req.is_write;
              mem_req_r.data_addr  <= {lin_bank, GPR_START | BANK_SIZE} +
                                      12'(lin_rem);
              mem_req_r.data_wdata <= ind_req.wdata;
              kind_r               <= !ind_req.is_write;
            end
          end
        end
        PCSIA_FLASH_WAIT: begin
          ind_rdata_r <= flash_rdata[7:0];
          ind_state_r <= PCSIA_IDLE;
        end
        default: ind_state_r <= PCSIA_IDLE;
      endcase
    end
  end

  // Register read port
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFF_PCL:    reg_rdata_r <= pc_r[7:0];
        OFF_PC_HIGH_LATCH: reg_rdata_r <= {1'b0, pc_high_latch_r};
        OFF_SP:     reg_rdata_r <= {3'h0, stack_pointer_reg_r};
        OFF_TOP_OF_STACK_LOW:   reg_rdata_r <= stack_mem[slot(stack_pointer_reg_r)][7:0];
        OFF_TOP_OF_STACK_HIGH:   reg_rdata_r <= {1'b0, stack_mem[slot(stack_pointer_reg_r)][14:8]};
        OFF_FSR0L:  reg_rdata_r <= ptr_lo_r[0];
        OFF_FSR0H:  reg_rdata_r <= ptr_hi_r[0];
        OFF_FSR1L:  reg_rdata_r <= ptr_lo_r[1];
        OFF_FSR1H:  reg_rdata_r <= ptr_hi_r[1];
        OFF_FLAGS:  reg_rdata_r <= {6'h00, stack_underflow_flag_r, stack_overflow_flag_r};
        default:    reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // Checks
  a_pc_reset_zero: assert property (@(posedge core_clk)
    sys_rst |=> pc_r == PC_RESET) else $error("pc not cleared by reset");
  a_pcl_write_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_hit(reg_req, OFF_PCL) && !stack_reset_req_r |=>
    pc_r == {$past(pc_high_latch_r), $past(reg_req.wdata)})
    else $error("pc low write did not take latch");
  a_call_target: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd.op == PCSIA_OP_CALL && !reg_hit(reg_req, OFF_PCL) && !stack_reset_req_r |=>
    pc_r[14:11] == 4'($past(pc_high_latch_r) >> 3) && pc_r[10:0] == $past(cmd.operand))
    else $error("call target wrong");
  a_brw_target: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd.op == PCSIA_OP_BRW && !reg_hit(reg_req, OFF_PCL) && !stack_reset_req_r |=>
    pc_r == 15'($past(pc_r) + 15'h0001 + {7'h00, $past(cmd.wreg)}))
    else $error("working branch target wrong");
  a_bra_target: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd.op == PCSIA_OP_BRA && !reg_hit(reg_req, OFF_PCL) && !stack_reset_req_r |=>
    pc_r == 15'($past(pc_r) + 15'h0001 + 15'(signed'($past(cmd.operand[8:0])))))
    else $error("immediate branch target wrong");
  a_latch_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
    (is_push || is_pop) && !reg_hit(reg_req, OFF_PC_HIGH_LATCH) |=> $stable(pc_high_latch_r))
    else $error("latch moved by push or pop");
  a_push_empty_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    is_push && stack_pointer_reg_r == SP_EMPTY && !stack_reset_req_r |=>
    stack_pointer_reg_r == 5'h00) else $error("first push not at entry 0");
  a_pop_to_empty: assert property (@(posedge core_clk) disable iff (sys_rst)
    is_pop && stack_pointer_reg_r == 5'h00 && !stack_reset_req_r |=>
    stack_pointer_reg_r == SP_EMPTY) else $error("last pop not empty");
  a_ovf_flag_set: assert property (@(posedge core_clk) disable iff (por_rst)
    ovf_ev |=> stack_overflow_flag_r) else $error("overflow flag missing");
  a_unf_flag_set: assert property (@(posedge core_clk) disable iff (por_rst)
    unf_ev |=> stack_underflow_flag_r) else $error("underflow flag missing");
  sequence s_err_reset;
    stack_reset_req_r ##1 pc_r == PC_RESET;
  endsequence
  a_err_reset_req: assert property (@(posedge core_clk) disable iff (sys_rst)
    stack_error_reset_enable && (ovf_ev || unf_ev) |=> s_err_reset)
    else $error("stack error did not reset");
  sequence s_flash_req;
    ind_req.valid && ind_addr[FLASH_BIT] && ind_state_r == PCSIA_IDLE;
  endsequence
  a_flash_extra: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_flash_req |=> ind_stall_r ##1 !ind_stall_r)
    else $error("flash access missing extra cycle");
  a_self_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    ind_req.valid && ind_state_r == PCSIA_IDLE && ind_addr <= IND_PORT1 |=>
    !mem_req_r.data_en && ind_rdata_r == 8'h00) else $error("self access not zero");
endmodule

// ### verif/pcsia_mem_model.sv
`timescale 1ns/100ps
// Memory side of the indirect port: reads answer while the registered request stands
module pcsia_mem_model
  import pcsia_pkg::*;
(
  // Clock
  input  wire logic                  core_clk,
  // Request from the block
  input  wire pcsia_pkg::pcsia_mem_req_s mem_req,
  // Read answers
  output logic [7:0]                 mem_rdata,
  output logic [13:0]                flash_rdata
);
  import pcsia_pkg::*;

  logic [7:0]  junk_data_r  = 8'hFF;
  logic [13:0] junk_flash_r = 14'h3FFF;

  // Outside the answer cycle the lines toggle, so a sample at the wrong edge never looks valid
  always @(posedge core_clk) begin
    junk_data_r  <= ~junk_data_r;
    junk_flash_r <= ~junk_flash_r;
  end

  // The block's request register acts as the memory address register: data follow it
  always_comb begin
    mem_rdata   = junk_data_r;
    flash_rdata = junk_flash_r;
    if (mem_req.data_en === 1'b1 && mem_req.data_wr === 1'b0) begin
      mem_rdata = mem_req.data_addr[7:0] ^ 8'h5A;
    end
    if (mem_req.flash_en === 1'b1) begin
      flash_rdata = mem_req.flash_addr[13:0] ^ 14'h2A5A;
    end
  end
endmodule

// ### verif/pcsia_core_bench.sv
`timescale 1ns/100ps
module pcsia_core_bench;
  import pcsia_pkg::*;
  logic           core_clk = 1'b0;
  logic           sys_rst = 1'b1;
  logic           por_rst = 1'b1;
  logic           stack_error_reset_enable = 1'b0;
  pcsia_cmd_s     cmd = '0;
  pcsia_reg_req_s reg_req = '0;
  pcsia_ind_req_s ind_req = '0;
  logic [14:0]    pc_r;
  logic           stack_reset_req_r;
  logic           ovf_r;
  logic           unf_r;
  logic [7:0]     reg_rdata_r;
  pcsia_mem_req_s mem_req_r;
  pcsia_mem_req_s snap;
  logic [7:0]     ind_rdata_r;
  logic           ind_stall_r;
  logic [7:0]     mem_rdata;
  logic [13:0]    flash_rdata;
  logic [7:0]     b;
  logic [7:0]     c;
  logic [7:0]     rd1;
  logic [7:0]     rd3;
  logic           saw;
  logic           saw_wr;
  logic           stl;
  int             bad_count = 0;
  int             tests_run = 0;
  int             rst_pulses = 0;

  pcsia_core #(.LIN_BANKS(32)) pcsia_core_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .por_rst(por_rst),
    .stack_error_reset_enable(stack_error_reset_enable), .cmd(cmd), .pc_r(pc_r),
    .stack_reset_req_r(stack_reset_req_r), .stack_overflow_flag_r(ovf_r),
    .stack_underflow_flag_r(unf_r), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
    .ind_req(ind_req), .mem_rdata(mem_rdata), .flash_rdata(flash_rdata),
    .mem_req_r(mem_req_r), .ind_rdata_r(ind_rdata_r), .ind_stall_r(ind_stall_r));
  pcsia_mem_model pcsia_mem_model_inst (
    .core_clk(core_clk), .mem_req(mem_req_r), .mem_rdata(mem_rdata),
    .flash_rdata(flash_rdata));

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (stack_reset_req_r === 1'b1) rst_pulses++;
  end

  task automatic chk15(input logic [14:0] got, input logic [14:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Counts: run=%0d bad=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic rst_all(input logic por);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    por_rst <= por;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    #1;
  endtask
  task automatic op_go(input pcsia_op_e op, input logic [10:0] opnd,
                       input logic [7:0] w, input logic [14:0] v);
    @(posedge core_clk);
    cmd <= '{op, opnd, w, v};
    @(posedge core_clk);
    cmd <= '0;
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
    d = reg_rdata_r;
  endtask
  // Fixed four-cycle watch: request, answer and stall all land inside it
  task automatic ind_go(input logic s, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    ind_req <= '{1'b1, w, s, d};
    saw = 1'b0;
    saw_wr = 1'b0;
    stl = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      @(posedge core_clk);
      if (i == 1) ind_req <= '0;
      #1;
      if (mem_req_r.data_en === 1'b1 || mem_req_r.flash_en === 1'b1) begin
        saw = 1'b1;
        snap = mem_req_r;
      end
      if (mem_req_r.data_en === 1'b1 && mem_req_r.data_wr === 1'b1) saw_wr = 1'b1;
      if (ind_stall_r === 1'b1) stl = 1'b1;
      if (i == 1) rd1 = ind_rdata_r;
      if (i == 3) rd3 = ind_rdata_r;
    end
    repeat (2) @(posedge core_clk);
  endtask

  task automatic t_reset();
    rst_all(1'b1);
    chk15(pc_r, PC_RESET);
    reg_rd(OFF_SP, b);
    chk8(b, 8'h1F);
    reg_rd(4'hF, b);
    chk8(b, 8'h00);
  endtask
  task automatic t_pc_flow();
    reg_wr(OFF_PC_HIGH_LATCH, 8'h35);
    reg_wr(OFF_PCL, 8'h12);
    chk15(pc_r, 15'h3512);
    reg_rd(OFF_PCL, b);
    chk8(b, 8'h12);
    op_go(PCSIA_OP_CALL, 11'h5A3, 8'h00, 15'h0000);
    chk15(pc_r, 15'h35A3);
    reg_rd(OFF_SP, b);
    chk8(b, 8'h00);
    reg_rd(OFF_TOP_OF_STACK_LOW, b);
    reg_rd(OFF_TOP_OF_STACK_HIGH, c);
    chk15({c[6:0], b}, 15'h3513);
    op_go(PCSIA_OP_RETURN, 11'h000, 8'h00, 15'h0000);
    chk15(pc_r, 15'h3513);
    reg_rd(OFF_SP, b);
    chk8(b, 8'h1F);
    reg_rd(OFF_PC_HIGH_LATCH, b);
    chk8(b, 8'h35);
    op_go(PCSIA_OP_CALL_VIA_WORKING, 11'h000, 8'h77, 15'h0000);
    chk15(pc_r, 15'h3577);
    reg_rd(OFF_TOP_OF_STACK_LOW, b);
    chk8(b, 8'h14);
    op_go(PCSIA_OP_RETURN_WITH_LITERAL, 11'h000, 8'h00, 15'h0000);
    chk15(pc_r, 15'h3514);
    op_go(PCSIA_OP_BRW, 11'h000, 8'hF0, 15'h0000);
    chk15(pc_r, 15'h3605);
    op_go(PCSIA_OP_BRA, 11'h7F0, 8'h00, 15'h0000);
    chk15(pc_r, 15'h35F6);
    op_go(PCSIA_OP_INC, 11'h000, 8'h00, 15'h0000);
    chk15(pc_r, 15'h35F7);
  endtask
  task automatic t_wrap();
    rst_all(1'b0);
    chk15(pc_r, PC_RESET);
    for (int k = 1; k <= 17; k++) begin
      op_go(PCSIA_OP_VECTOR, 11'h000, 8'h00, 15'h0100 + 15'(k));
      if (k == 16) chk1(ovf_r, 1'b0);
    end
    chk1(ovf_r, 1'b1);
    chk8(8'(rst_pulses), 8'h00);
    reg_wr(OFF_SP, 8'h00);
    reg_rd(OFF_TOP_OF_STACK_LOW, b);
    reg_rd(OFF_TOP_OF_STACK_HIGH, c);
    chk15({c[6:0], b}, 15'h0110);
    reg_wr(OFF_SP, 8'h01);
    reg_rd(OFF_TOP_OF_STACK_LOW, b);
    reg_rd(OFF_TOP_OF_STACK_HIGH, c);
    chk15({c[6:0], b}, 15'h0101);
  endtask
  task automatic t_unf();
    rst_all(1'b1);
    @(posedge core_clk);
    stack_error_reset_enable <= 1'b1;
    op_go(PCSIA_OP_RETURN_FROM_INTERRUPT, 11'h000, 8'h00, 15'h0000);
    #8;
    chk1(unf_r, 1'b1);
    chk8(8'(rst_pulses), 8'h01);
    reg_rd(OFF_FLAGS, b);
    chk8(b & 8'h03, 8'h02);
    @(posedge core_clk);
    stack_error_reset_enable <= 1'b0;
    rst_all(1'b0);
  endtask
  task automatic t_ind();
    reg_wr(OFF_FSR0H, 8'h20);
    reg_wr(OFF_FSR0L, 8'h50);
    ind_go(1'b0, 1'b0, 8'h00);
    chk1(saw, 1'b1);
    chk15(15'(snap.data_addr), 15'h00A0);
    chk8(rd3, 8'hFA);
    chk1(stl, 1'b0);
    reg_wr(OFF_FSR1H, 8'h00);
    reg_wr(OFF_FSR1L, 8'h01);
    ind_go(1'b1, 1'b0, 8'h00);
    chk8(rd1, 8'h00);
    chk1(saw, 1'b0);
    ind_go(1'b1, 1'b1, 8'hC3);
    chk1(saw_wr, 1'b0);
    reg_wr(OFF_FSR1H, 8'h0F);
    reg_wr(OFF_FSR1L, 8'hFF);
    ind_go(1'b1, 1'b1, 8'hC3);
    chk1(saw_wr, 1'b1);
    chk15(15'(snap.data_addr), 15'h0FFF);
    chk8(snap.data_wdata, 8'hC3);
    reg_wr(OFF_FSR0H, 8'h81);
    reg_wr(OFF_FSR0L, 8'h23);
    ind_go(1'b0, 1'b0, 8'h00);
    chk15(snap.flash_addr, 15'h0123);
    chk1(stl, 1'b1);
    chk8(rd3, 8'h79);
    reg_wr(OFF_FSR1H, 8'h29);
    reg_wr(OFF_FSR1L, 8'hB0);
    ind_go(1'b1, 1'b0, 8'h00);
    chk8(rd1, 8'h00);
    chk1(saw, 1'b0);
    ind_go(1'b0, 1'b1, 8'h55);
    chk1(saw_wr, 1'b0);
  endtask

  // Guard against a hung design
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial begin
    t_reset();
    t_pc_flow();
    t_wrap();
    t_unf();
    t_ind();
    wrap_up();
  end
endmodule
